// ### src/rdc_defs.svh
// constants of the instruction decoder
`ifndef RDC_DEFS_SVH
`define RDC_DEFS_SVH
`define RDC_CYC_CLKS 4
`define RDC_PH_LAST  2'(`RDC_CYC_CLKS - 1)
`define RDC_WB_CTRL  8'h00
`define RDC_WB_STAT  8'h04
`define RDC_WB_ACC   8'h08
`define RDC_WB_TMR   8'h0C
`define RDC_F_IND    5'h00
`define RDC_F_TMR    5'h01
`define RDC_F_PCL    5'h02
`define RDC_F_STAT   5'h03
`define RDC_F_FSR    5'h04
`define RDC_F_PA     5'h05
`define RDC_F_PB     5'h06
`define RDC_F_RAM0   7
`define RDC_ST_C     0
`define RDC_ST_DC    1
`define RDC_ST_Z     2
`define RDC_ST_PD    3
`define RDC_ST_TO    4
`define RDC_OPT_PSA  3
`define RDC_OPT_CS   5
`define RDC_ST_RST   8'h18
`define RDC_OPT_RST  8'h3F
`define RDC_PC_RST   11'h000
`define RDC_NOP      12'h000
`endif

// ### src/rdc_pkg.sv
// types of the instruction decoder
package rdc_pkg;
   typedef enum logic [4:0] {
      OP_NOP, OP_OPTION, OP_SLEEP, OP_WATCHDOG_CLEAR, OP_LOAD_TRISTATE, OP_STORE_ACC,
      OP_CLR, OP_SUB, OP_DEC, OP_IOR, OP_AND, OP_XOR, OP_ADD,
      OP_MOVE_FILE, OP_INVERT_FILE, OP_INC, OP_DECSZ, OP_RRF, OP_RLF, OP_SWAP,
      OP_INCSZ, OP_BCF, OP_BSF, OP_TEST_SKIP_IF_CLEAR, OP_TEST_SKIP_IF_SET, OP_RETURN_WITH_LITERAL,
      OP_CALL, OP_JUMP_OP, OP_LOAD_LITERAL, OP_OR_LITERAL, OP_AND_LITERAL, OP_XOR_LITERAL
   } rdc_op_e;
   typedef struct packed {
      logic z_en;
      logic c_en;
      logic dc_en;
      logic c;
      logic dc;
   } rdc_flag_s;
endpackage

// ### src/rdc_top.sv
// decode and execute core with wishbone control slave
`include "rdc_defs.svh"
module rdc_top
   import rdc_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic      [10:0] prog_addr_o,
   input  wire logic [11:0] prog_word_i,
   input  wire logic [7:0]  port_first_pin_i,
   output logic      [7:0]  port_first_o,
   output logic      [7:0]  port_first_oe_o,
   input  wire logic [7:0]  port_second_pin_i,
   output logic      [7:0]  port_second_o,
   output logic      [7:0]  port_second_oe_o,
   output logic             sleep_o,
   output logic             wdt_overflow_o
);
   function automatic rdc_op_e op_decode(input logic [11:0] w);
      rdc_op_e o;
      o = OP_NOP;
      if (w[11:10] == 2'b00)
      begin
         case (w[9:6])
            4'h0:
            begin
               if (w[5]) o = OP_STORE_ACC;
               else if (w[4:0] == 5'h02) o = OP_OPTION;
               else if (w[4:0] == 5'h03) o = OP_SLEEP;
               else if (w[4:0] == 5'h04) o = OP_WATCHDOG_CLEAR;
               else if (w[4:3] == 2'b00 && w[2:0] >= 3'h5) o = OP_LOAD_TRISTATE;
            end
            4'h1: o = OP_CLR;
            4'h2: o = OP_SUB;
            4'h3: o = OP_DEC;
            4'h4: o = OP_IOR;
            4'h5: o = OP_AND;
            4'h6: o = OP_XOR;
            4'h7: o = OP_ADD;
            4'h8: o = OP_MOVE_FILE;
            4'h9: o = OP_INVERT_FILE;
            4'hA: o = OP_INC;
            4'hB: o = OP_DECSZ;
            4'hC: o = OP_RRF;
            4'hD: o = OP_RLF;
            4'hE: o = OP_SWAP;
            default: o = OP_INCSZ;
         endcase
      end
      else if (w[11:10] == 2'b01)
      begin
         case (w[9:8])
            2'h0: o = OP_BCF;
            2'h1: o = OP_BSF;
            2'h2: o = OP_TEST_SKIP_IF_CLEAR;
            default: o = OP_TEST_SKIP_IF_SET;
         endcase
      end
      else
      begin
         case (w[11:8])
            4'h8: o = OP_RETURN_WITH_LITERAL;
            4'h9: o = OP_CALL;
            4'hC: o = OP_LOAD_LITERAL;
            4'hD: o = OP_OR_LITERAL;
            4'hE: o = OP_AND_LITERAL;
            4'hF: o = OP_XOR_LITERAL;
            default: o = OP_JUMP_OP;
         endcase
      end
      return o;
   endfunction

   logic [1:0]  phase_reg;
   logic        run_reg;
   logic        sleep_reg;
   logic [11:0] instr_reg;
   logic [10:0] pc_reg;
   logic [10:0] stack_top_reg;
   logic [10:0] stack_low_reg;
   logic [7:0]  acc_reg;
   logic [7:0]  status_reg;
   logic [7:0]  status_next;
   logic [7:0]  option_reg;
   logic [7:0]  fsr_reg;
   logic [7:0]  timer_register_reg;
   logic [7:0]  pre_reg;
   logic [7:0]  watchdog_counter_reg;
   logic [7:0]  ram_reg [32];
   logic        exec_tick;
   logic        wb_hit;
   rdc_op_e     op;
   rdc_flag_s   fl;
   logic [4:0]  fa;
   logic [7:0]  fv;
   logic [7:0]  lit;
   logic [7:0]  res;
   logic [7:0]  bmask;
   logic [8:0]  s9;
   logic [4:0]  s5;
   logic        bdst;
   logic        to_acc;
   logic        to_file;
   logic        skip;
   logic        branch;
   logic        push;
   logic        pop;
   logic [10:0] target;
   logic        psa;
   logic [7:0]  tmask;
   logic [7:0]  wmask;
   logic        tmr_write;
   logic        wdt_clr;
   logic        w_inc;
   logic        wdt_ovf;

   assign exec_tick = phase_reg == `RDC_PH_LAST && run_reg && !sleep_reg;
   assign prog_addr_o = pc_reg;
   assign sleep_o = sleep_reg;
   assign op = op_decode(instr_reg);
   assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

   // four-phase cadence
   always_ff @(posedge clk_i)
   begin
      if (rst_i) phase_reg <= 2'h0;
      else phase_reg <= phase_reg + 2'h1;
   end

   always_comb
   begin
      fa = (instr_reg[4:0] == `RDC_F_IND) ? fsr_reg[4:0] : instr_reg[4:0];
      if (fa == `RDC_F_IND) fv = 8'h00;
      else if (fa == `RDC_F_TMR) fv = timer_register_reg;
      else if (fa == `RDC_F_PCL) fv = pc_reg[7:0];
      else if (fa == `RDC_F_STAT) fv = status_reg;
      else if (fa == `RDC_F_FSR) fv = fsr_reg;
      else if (fa == `RDC_F_PA) fv = port_first_pin_i;
      else if (fa == `RDC_F_PB) fv = port_second_pin_i;
      else fv = ram_reg[fa];
      lit = instr_reg[7:0];
      bmask = 8'h01 << instr_reg[7:5];
      bdst = instr_reg[11:10] == 2'b00 && instr_reg[9:6] != 4'h0;
      s9 = 9'h000;
      s5 = 5'h00;
      res = fv;
      fl = '0;
      to_acc = 1'b0;
      to_file = 1'b0;
      skip = 1'b0;
      branch = 1'b0;
      push = 1'b0;
      pop = 1'b0;
      target = pc_reg;
      case (op)
         OP_STORE_ACC: begin res = acc_reg; to_file = 1'b1; end
         OP_CLR: begin res = 8'h00; fl.z_en = 1'b1; end
         OP_SUB:
         begin
            s9 = {1'b0, fv} + {1'b0, ~acc_reg} + 9'h001;
            s5 = {1'b0, fv[3:0]} + {1'b0, ~acc_reg[3:0]} + 5'h01;
            res = s9[7:0];
            fl = '{1'b1, 1'b1, 1'b1, s9[8], s5[4]};
         end
         OP_ADD:
         begin
            s9 = {1'b0, fv} + {1'b0, acc_reg};
            s5 = {1'b0, fv[3:0]} + {1'b0, acc_reg[3:0]};
            res = s9[7:0];
            fl = '{1'b1, 1'b1, 1'b1, s9[8], s5[4]};
         end
         OP_DEC: begin res = fv - 8'h01; fl.z_en = 1'b1; end
         OP_IOR: begin res = acc_reg | fv; fl.z_en = 1'b1; end
         OP_AND: begin res = acc_reg & fv; fl.z_en = 1'b1; end
         OP_XOR: begin res = acc_reg ^ fv; fl.z_en = 1'b1; end
         OP_MOVE_FILE: fl.z_en = 1'b1;
         OP_INVERT_FILE: begin res = ~fv; fl.z_en = 1'b1; end
         OP_INC: begin res = fv + 8'h01; fl.z_en = 1'b1; end
         OP_DECSZ: begin res = fv - 8'h01; skip = res == 8'h00; end
         OP_INCSZ: begin res = fv + 8'h01; skip = res == 8'h00; end
         OP_RRF:
         begin
            res = {status_reg[`RDC_ST_C], fv[7:1]};
            fl.c_en = 1'b1;
            fl.c = fv[0];
         end
         OP_RLF:
         begin
            res = {fv[6:0], status_reg[`RDC_ST_C]};
            fl.c_en = 1'b1;
            fl.c = fv[7];
         end
         OP_SWAP: res = {fv[3:0], fv[7:4]};
         OP_BCF: begin res = fv & ~bmask; to_file = 1'b1; end
         OP_BSF: begin res = fv | bmask; to_file = 1'b1; end
         OP_TEST_SKIP_IF_CLEAR: skip = (fv & bmask) == 8'h00;
         OP_TEST_SKIP_IF_SET: skip = (fv & bmask) != 8'h00;
         OP_RETURN_WITH_LITERAL:
         begin
            res = lit;
            to_acc = 1'b1;
            pop = 1'b1;
            branch = 1'b1;
            target = stack_top_reg;
         end
         OP_CALL:
         begin
            push = 1'b1;
            branch = 1'b1;
            target = {status_reg[6:5], 1'b0, lit};
         end
         OP_JUMP_OP:
         begin
            branch = 1'b1;
            target = {status_reg[6:5], instr_reg[8:0]};
         end
         OP_LOAD_LITERAL: begin res = lit; to_acc = 1'b1; end
         OP_OR_LITERAL: begin res = acc_reg | lit; to_acc = 1'b1; fl.z_en = 1'b1; end
         OP_AND_LITERAL: begin res = acc_reg & lit; to_acc = 1'b1; fl.z_en = 1'b1; end
         OP_XOR_LITERAL: begin res = acc_reg ^ lit; to_acc = 1'b1; fl.z_en = 1'b1; end
         default: res = fv;
      endcase
      if (bdst)
      begin
         to_file = instr_reg[5];
         to_acc = !instr_reg[5];
      end
      if (to_file && fa == `RDC_F_PCL)
      begin
         branch = 1'b1;
         target = {status_reg[6:5], 1'b0, res};
      end
   end

   // fetch, pc and the discard of a prefetched word
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pc_reg <= `RDC_PC_RST;
         instr_reg <= `RDC_NOP;
      end
      else if (exec_tick)
      begin
         pc_reg <= branch ? target : pc_reg + 11'h001;
         instr_reg <= (branch || skip) ? `RDC_NOP : prog_word_i;
      end
   end

   // two level return stack
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         stack_top_reg <= 11'h000;
         stack_low_reg <= 11'h000;
      end
      else if (exec_tick && push)
      begin
         stack_low_reg <= stack_top_reg;
         stack_top_reg <= pc_reg;
      end
      else if (exec_tick && pop) stack_top_reg <= stack_low_reg;
   end

   // accumulator, option, pointer
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         acc_reg <= 8'h00;
         option_reg <= `RDC_OPT_RST;
         fsr_reg <= 8'h00;
      end
      else if (exec_tick)
      begin
         if (to_acc) acc_reg <= res;
         if (op == OP_OPTION) option_reg <= acc_reg;
         if (to_file && fa == `RDC_F_FSR) fsr_reg <= res;
      end
   end

   generate
      for (genvar i = 0; i < 32; i++)
      begin : g_ram
         always_ff @(posedge clk_i)
         begin
            if (rst_i) ram_reg[i] <= 8'h00;
            else if (exec_tick && to_file && fa == 5'(i) && i >= `RDC_F_RAM0)
               ram_reg[i] <= res;
         end
      end
   endgenerate

   // status flags; watchdog overflow clearing timeout is never lost
   always_comb
   begin
      status_next = status_reg;
      if (exec_tick)
      begin
         if (to_file && fa == `RDC_F_STAT)
            status_next = {res[7:5], status_reg[4:3], res[2:0]};
         if (fl.c_en) status_next[`RDC_ST_C] = fl.c;
         if (fl.dc_en) status_next[`RDC_ST_DC] = fl.dc;
         if (fl.z_en) status_next[`RDC_ST_Z] = res == 8'h00;
         if (op == OP_SLEEP) status_next[4:3] = 2'b10;
         if (op == OP_WATCHDOG_CLEAR) status_next[4:3] = 2'b11;
      end
      if (wdt_ovf) status_next[`RDC_ST_TO] = 1'b0;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i) status_reg <= `RDC_ST_RST;
      else status_reg <= status_next;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i) sleep_reg <= 1'b0;
      else if (exec_tick && op == OP_SLEEP) sleep_reg <= 1'b1;
   end

   // port latches and tristate enables
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         port_first_o <= 8'h00;
         port_second_o <= 8'h00;
         port_first_oe_o <= 8'h00;
         port_second_oe_o <= 8'h00;
      end
      else if (exec_tick)
      begin
         if (to_file && fa == `RDC_F_PA) port_first_o <= res;
         if (to_file && fa == `RDC_F_PB) port_second_o <= res;
         if (op == OP_LOAD_TRISTATE && instr_reg[4:0] == `RDC_F_PA)
            port_first_oe_o <= ~acc_reg;
         if (op == OP_LOAD_TRISTATE && instr_reg[4:0] == `RDC_F_PB)
            port_second_oe_o <= ~acc_reg;
      end
   end

   // timer, shared prescaler, watchdog
   assign psa = option_reg[`RDC_OPT_PSA];
   assign tmask = 8'hFF >> (3'h7 - option_reg[2:0]);
   assign wmask = 8'h7F >> (3'h7 - option_reg[2:0]);
   assign tmr_write = exec_tick && to_file && fa == `RDC_F_TMR;
   assign wdt_clr = exec_tick && (op == OP_WATCHDOG_CLEAR || op == OP_SLEEP);
   assign w_inc = phase_reg == `RDC_PH_LAST && (!psa || (pre_reg & wmask) == wmask);
   assign wdt_ovf = w_inc && !wdt_clr && watchdog_counter_reg == 8'hFF;

   always_ff @(posedge clk_i)
   begin
      if (rst_i) pre_reg <= 8'h00;
      else if ((tmr_write && !psa) || (wdt_clr && psa)) pre_reg <= 8'h00;
      else if (psa ? phase_reg == `RDC_PH_LAST : exec_tick && !option_reg[`RDC_OPT_CS])
         pre_reg <= pre_reg + 8'h01;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i) timer_register_reg <= 8'h00;
      else if (tmr_write) timer_register_reg <= res;
      else if (exec_tick && !option_reg[`RDC_OPT_CS] && (psa || (pre_reg & tmask) == tmask))
         timer_register_reg <= timer_register_reg + 8'h01;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         watchdog_counter_reg <= 8'h00;
         wdt_overflow_o <= 1'b0;
      end
      else
      begin
         wdt_overflow_o <= wdt_ovf;
         if (wdt_clr) watchdog_counter_reg <= 8'h00;
         else if (w_inc) watchdog_counter_reg <= watchdog_counter_reg + 8'h01;
      end
   end

   // wishbone slave
   always_ff @(posedge clk_i)
   begin
      if (rst_i) wb_ack_o <= 1'b0;
      else wb_ack_o <= wb_hit;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i) run_reg <= 1'b0;
      else if (wb_hit && wb_we_i && wb_adr_i == `RDC_WB_CTRL && wb_sel_i[0])
         run_reg <= wb_dat_i[0];
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i) wb_dat_o <= 32'h0000_0000;
      else if (wb_hit)
      begin
         if (wb_adr_i == `RDC_WB_CTRL) wb_dat_o <= {31'h0, run_reg};
         else if (wb_adr_i == `RDC_WB_STAT) wb_dat_o <= {13'h0, pc_reg, status_reg};
         else if (wb_adr_i == `RDC_WB_ACC) wb_dat_o <= {24'h0, acc_reg};
         else if (wb_adr_i == `RDC_WB_TMR)
            wb_dat_o <= {8'h0, watchdog_counter_reg, timer_register_reg, option_reg};
         else wb_dat_o <= 32'h0000_0000;
      end
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_phases;
      phase_reg == 2'h0 ##1 phase_reg == 2'h1 ##1 phase_reg == 2'h2;
   endsequence
   sequence s_asleep;
      sleep_reg && status_reg[4:3] == 2'b10;
   endsequence

   phase_cadence_a: assert property (phase_reg == 2'h3 |=> s_phases)
      else $error("phase not four-step");
   skip_discard_a: assert property (exec_tick && skip |=> instr_reg == 12'h000)
      else $error("skip kept prefetched word");
   jump_target_a: assert property (exec_tick && op == OP_JUMP_OP |=>
      pc_reg == {$past(status_reg[6:5]), $past(instr_reg[8:0])} && instr_reg == 12'h000)
      else $error("jump target wrong");
   call_push_a: assert property (exec_tick && op == OP_CALL |=>
      stack_top_reg == $past(pc_reg) && pc_reg[8] == 1'b0 && pc_reg[7:0] == $past(lit))
      else $error("call wrong");
   return_lit_a: assert property (exec_tick && op == OP_RETURN_WITH_LITERAL |=>
      acc_reg == $past(lit) && pc_reg == $past(stack_top_reg))
      else $error("return wrong");
   load_tristate_load_a: assert property (exec_tick && op == OP_LOAD_TRISTATE && instr_reg[2:0] == 3'h5 |=>
      port_first_oe_o == ~$past(acc_reg))
      else $error("tristate load wrong");
   bit_flags_a: assert property (exec_tick && fa != 5'h03 && !wdt_ovf &&
      (op == OP_BCF || op == OP_BSF || op == OP_TEST_SKIP_IF_CLEAR || op == OP_TEST_SKIP_IF_SET) |=>
      $stable(status_reg))
      else $error("bit op changed flags");
   sleep_enter_a: assert property (exec_tick && op == OP_SLEEP && !wdt_ovf |=>
      s_asleep ##1 sleep_reg[*3])
      else $error("standby not entered");
   wdt_clear_a: assert property (exec_tick && op == OP_WATCHDOG_CLEAR |=>
      watchdog_counter_reg == 8'h00 && status_reg[4:3] == 2'b11)
      else $error("watchdog clear wrong");
   and_literal_zero_a: assert property (exec_tick && op == OP_AND_LITERAL |=>
      status_reg[2] == ((acc_reg) == 8'h00) && acc_reg == ($past(acc_reg) & $past(lit)))
      else $error("literal and wrong");
   pcl_page_a: assert property (exec_tick && to_file && fa == 5'h02 |=>
      pc_reg[8] == 1'b0 && instr_reg == 12'h000)
      else $error("pc write kept bit eight");
endmodule

// ### verification/rdc_prog_mem.sv
// program memory model answering the fetch address
module rdc_prog_mem
#(
   parameter int SLOW = 0
)
(
   input  wire logic        clk_i,
   input  wire logic [10:0] addr_i,
   output logic      [11:0] word_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [11:0] mem [0:2047];
   logic [10:0] last_addr;
   int          wait_cnt;
   initial
   begin
      foreach (mem[i])
         mem[i] = 12'h000;
      last_addr = 11'h000;
      wait_cnt = 0;
      word_o = 12'h000;
   end
   // new address: junk for SLOW+1 cycles, then the word
   always @(posedge clk_i)
   begin
      if (addr_i !== last_addr)
      begin
         last_addr <= addr_i;
         wait_cnt <= SLOW;
         word_o <= ~word_o;
      end
      else if (wait_cnt > 0)
      begin
         wait_cnt <= wait_cnt - 1;
         word_o <= ~word_o;
      end
      else
         word_o <= mem[addr_i];
   end
endmodule

// ### verification/risc_12bit_instruction_decoder_tb_top.sv
// self-checking bench of the instruction decoder
module risc_12bit_instruction_decoder_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_i;
   logic        rst_i;
   logic        wb_cyc_i;
   logic        wb_stb_i;
   logic        wb_we_i;
   logic        wb_ack_o;
   logic        sleep_o;
   logic        wdt_ovf;
   logic [7:0]  wb_adr_i;
   logic [7:0]  pa_ext;
   logic [7:0]  pb_ext;
   logic [7:0]  pa_pin;
   logic [7:0]  pb_pin;
   logic [7:0]  pa_o;
   logic [7:0]  pa_oe;
   logic [7:0]  pb_o;
   logic [7:0]  pb_oe;
   logic [31:0] wb_dat_i;
   logic [31:0] wb_dat_o;
   logic [31:0] rd;
   logic [10:0] prog_addr;
   logic [11:0] prog_word;
   int          n_errors = 0;
   int          cmp_count = 0;

   // pin level from latch where driven, else the outside world
   assign pa_pin = (pa_oe & pa_o) | (~pa_oe & pa_ext);
   assign pb_pin = (pb_oe & pb_o) | (~pb_oe & pb_ext);

   rdc_top uut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .prog_addr_o(prog_addr),
      .prog_word_i(prog_word), .port_first_pin_i(pa_pin), .port_first_o(pa_o),
      .port_first_oe_o(pa_oe), .port_second_pin_i(pb_pin), .port_second_o(pb_o),
      .port_second_oe_o(pb_oe), .sleep_o(sleep_o), .wdt_overflow_o(wdt_ovf));

   rdc_prog_mem #(.SLOW(1)) pm (.clk_i(clk_i), .addr_i(prog_addr), .word_o(prog_word));

   initial
   begin
      clk_i = 1'b0;
      forever
         #50 clk_i = ~clk_i;
   end

   task automatic stop_test;
      $display("errors %0d comparisons %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1)
         @(posedge clk_i);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(nm, rd & m, e);
   endtask

   task automatic ld(input logic [10:0] base, input logic [11:0] p[]);
      foreach (p[i])
         pm.mem[base + 11'(i)] = p[i];
   endtask

   // reset, set the run bit, let the program settle in its loop
   task automatic go;
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b1, 8'h00, 32'h1);
      repeat (140) @(posedge clk_i);
   endtask

   task automatic t_arith;
      logic [10:0] a0;
      int          k;
      ld(0, '{12'hC17, 12'h027, 12'hCC2, 12'h1C7, 12'h1E7, 12'h087, 12'h1A7, 12'h167,
              12'h207, 12'hA09});
      go();
      a0 = prog_addr;
      while (prog_addr === a0)
         @(posedge clk_i);
      a0 = prog_addr;
      k = 0;
      while (prog_addr === a0)
      begin
         @(posedge clk_i);
         k++;
      end
      chk("instr period", k, 32'd4);
      rc("acc", 8'h08, 32'hFF, 32'h07);
      rc("status", 8'h04, 32'hFF, 32'h19);
      rc("ctrl", 8'h00, 32'h1, 32'h1);
      rc("unmapped", 8'h10, 32'hFFFFFFFF, 32'h0);
   endtask

   task automatic t_skip;
      ld(0, '{12'hC01, 12'h029, 12'h2E9, 12'hC55, 12'h5E9, 12'h7E9, 12'hC66, 12'h6C9,
              12'hC77, 12'h709, 12'h3C9, 12'hF01, 12'hA0C});
      go();
      rc("acc", 8'h08, 32'hFF, 32'h80);
      rc("status", 8'h04, 32'hFF, 32'h18);
   endtask

   task automatic t_rot;
      ld(0, '{12'hC81, 12'h02A, 12'h36A, 12'h30A, 12'h38A, 12'hD03, 12'hEF0, 12'h26A,
              12'h20A, 12'h06B, 12'h002, 12'hA0B});
      go();
      rc("acc", 8'h08, 32'hFF, 32'hFD);
      rc("status", 8'h04, 32'hFF, 32'h1C);
      rc("option", 8'h0C, 32'hFF, 32'hFD);
   endtask

   task automatic t_ctl;
      ld(0, '{12'h910, 12'hF3C, 12'hB05, 12'hCEE});
      ld(11'h010, '{12'h83C});
      ld(11'h105, '{12'hC20, 12'h022});
      ld(11'h020, '{12'hA20});
      go();
      chk("pc", {21'h0, prog_addr & 11'h7FE}, 32'h020);
      rc("status", 8'h04, 32'hFF, 32'h1C);
      rc("acc", 8'h08, 32'hFF, 32'h20);
   endtask

   task automatic t_port;
      pa_ext <= 8'h5A;
      pb_ext <= 8'h3C;
      ld(0, '{12'hCF0, 12'h005, 12'hC0F, 12'h006, 12'hCAA, 12'h025, 12'h206, 12'h265,
              12'h004, 12'h003, 12'hC99, 12'hA0B});
      go();
      chk("oe first", pa_oe, 32'h0F);
      chk("oe second", pb_oe, 32'hF0);
      chk("latch first", pa_o, 32'hA5);
      chk("standby", sleep_o, 32'h1);
      rc("acc", 8'h08, 32'hFF, 32'h0C);
      rc("status", 8'h04, 32'hFF, 32'h10);
   endtask

   // unscaled watchdog wraps once in the window; timeout bit drops
   task automatic t_wdt;
      int k;
      ld(0, '{12'hC07, 12'h002, 12'h02C, 12'h40C, 12'h0EC, 12'h28C, 12'h10C, 12'h026,
              12'hA08});
      go();
      k = 0;
      repeat (1100)
      begin
         @(posedge clk_i);
         if (wdt_ovf === 1'b1)
            k++;
      end
      chk("wdt wraps", k, 32'd1);
      chk("latch second", pb_o, 32'h07);
      rc("acc", 8'h08, 32'hFF, 32'h07);
      rc("status", 8'h04, 32'hFF, 32'h08);
   endtask

   initial
   begin
      repeat (20000) @(posedge clk_i);
      n_errors++;
      stop_test();
   end

   initial
   begin
      rst_i = 1'b1;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 8'h00;
      wb_dat_i = 32'h0;
      pa_ext = 8'h00;
      pb_ext = 8'h00;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      t_arith();
      t_skip();
      t_rot();
      t_ctl();
      t_port();
      t_wdt();
      stop_test();
   end
endmodule
